//--- hw/vpss_pkg.sv
/*
 * Package for the per-socket video port support block: register offsets,
 * field positions, reset values, oscillator timing and shared structs.
 * Assumes a single 250 MHz clock domain.
 */
package vpss_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] VPSS_OFS_SOCKET_CONTROL = 8'h10;
	localparam logic [7:0] VPSS_OFS_SYSTEM_CONTROL = 8'h80;
	localparam logic [7:0] VPSS_OFS_PRESENT_STATE = 8'h08;
	localparam logic [7:0] VPSS_OFS_FORCE_EVENT = 8'h0C;
	// ==========================================================
	// Field positions
	localparam int VPSS_BIT_VIDEO_ENABLE = 9;
	localparam int VPSS_BIT_STD_MODEL = 10;
	localparam int VPSS_BIT_VIDEO_IN_USE = 11;
	localparam int VPSS_BIT_SWITCH_CLOCK = 27;
	localparam int VPSS_BIT_PLATFORM_SUPPORT = 27;
	// ==========================================================
	// Reset values and options
	localparam logic VPSS_RST_SWITCH_CLOCK = 1'b0;
	localparam logic VPSS_RST_VIDEO_ENABLE = 1'b0;
	localparam logic VPSS_RST_PLATFORM_SUPPORT = 1'b0;
	localparam logic VPSS_STD_MODEL_IMPL = 1'b1;
	// ==========================================================
	// Oscillator timing: nominal 16 kHz from a 250 MHz clock
	localparam int VPSS_CLOCK_HZ = 250_000_000;
	localparam int VPSS_OSC_HZ = 16_000;
	localparam int VPSS_OSC_HALF_CYCLES = VPSS_CLOCK_HZ / (2 * VPSS_OSC_HZ);
	localparam int VPSS_OSC_CNT_W = 14;
	// ==========================================================
	// Register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic sock;
	} vpss_req_s;
	// Card type seen in a socket
	typedef enum logic [1:0] {
		VPSS_CARD_NONE,
		VPSS_CARD_16BIT,
		VPSS_CARD_CARDBUS
	} vpss_card_e;
endpackage : vpss_pkg

//--- hw/vpss_ring_osc.sv
/*
 * Low-rate oscillator model: divides the system clock to a nominal
 * 32 kHz enable pulse and a 16 kHz square output while enabled.
 * Assumes the enable comes from the same clock domain.
 */
`timescale 1ns/1ns
module vpss_ring_osc
	import vpss_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Control
	input wire logic i_enable,
	// Outputs
	output logic o_tick,
	output logic o_osc
);
	localparam logic [VPSS_OSC_CNT_W-1:0] LAST =
		VPSS_OSC_CNT_W'(VPSS_OSC_HALF_CYCLES - 1);
	logic [VPSS_OSC_CNT_W-1:0] cnt_q;
	logic [VPSS_OSC_CNT_W-1:0] cnt_d;
	logic wrap;
	assign wrap = (cnt_q == LAST);
	// Counter held in reset while disabled, so it is silent by default
	assign cnt_d = (!i_enable || wrap) ? '0 : cnt_q + 1'b1;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
			o_tick <= 1'b0;
			o_osc <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_tick <= i_enable && wrap;
			o_osc <= i_enable ? (o_osc ^ wrap) : 1'b0;
		end
	end
endmodule : vpss_ring_osc

//--- hw/vpss_top.sv
/*
 * Dual-socket video port support: socket control, present state, force
 * event and system control registers; oscillator enable; status-change
 * pin pull selection per card type.
 * Assumes a synchronous single-cycle register port with read data one
 * cycle after the read strobe; card type inputs come from pins.
 */
`timescale 1ns/1ns
// Contract
// - Standard-model flag reads one when implemented
// - Oscillator runs only while switch clock set
// - Power-down and interrogation run from oscillator alone (here: i_clock flops enabled by the oscillator tick)
// - Pull-up for 16-bit, pull-down for CardBus
// - Video-in-use set when either socket enabled
// - Force bit sets platform support bit
module vpss_top
	import vpss_pkg::*;
(
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Register port
	input wire vpss_req_s i_req,
	output logic [31:0] o_rdata,
	output logic o_rvalid,
	// Card type pins, per socket
	input wire logic [1:0] i_card_16bit,
	input wire logic [1:0] i_card_cardbus,
	// Status-change pin pull control, per socket
	output logic [1:0] o_pullup_en,
	output logic [1:0] o_pulldown_en,
	// Socket power-down and interrogation timing
	input wire logic [1:0] i_powerdown_req,
	output logic [1:0] o_socket_powered,
	output logic o_osc_clock,
	output logic o_osc_tick
);
	// ==========================================================
	// Input synchronisers
	// Card pins and power-down requests are asynchronous: two flops each
	logic [1:0] c16_m_q;
	logic [1:0] c16_q;
	logic [1:0] ccb_m_q;
	logic [1:0] ccb_q;
	logic [1:0] pd_m_q;
	logic [1:0] pd_q;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			c16_m_q <= '0;
			c16_q <= '0;
		end else begin
			c16_m_q <= i_card_16bit;
			c16_q <= c16_m_q;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ccb_m_q <= '0;
			ccb_q <= '0;
		end else begin
			ccb_m_q <= i_card_cardbus;
			ccb_q <= ccb_m_q;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pd_m_q <= '0;
			pd_q <= '0;
		end else begin
			pd_m_q <= i_powerdown_req;
			pd_q <= pd_m_q;
		end
	end
	// ==========================================================
	// Register decode
	logic switch_clock_select_q;
	logic [1:0] socket_video_enable_q;
	logic [1:0] platform_video_support_q;
	logic s;
	logic [1:0] sock_sel;
	logic addr_sock_ctl;
	logic addr_present;
	logic addr_sys_ctl;
	logic wr_sock_ctl;
	logic wr_sys_ctl;
	logic wr_force;
	logic wdata_enable;
	logic wdata_switch;
	logic wdata_force;
	logic video_in_use;
	assign s = i_req.sock;
	assign sock_sel = {s, !s};
	assign addr_sock_ctl = (i_req.addr == VPSS_OFS_SOCKET_CONTROL);
	assign addr_present = (i_req.addr == VPSS_OFS_PRESENT_STATE);
	assign addr_sys_ctl = (i_req.addr == VPSS_OFS_SYSTEM_CONTROL);
	assign wr_sock_ctl = i_req.wr && addr_sock_ctl;
	assign wr_sys_ctl = i_req.wr && addr_sys_ctl;
	assign wr_force = i_req.wr && (i_req.addr == VPSS_OFS_FORCE_EVENT);
	assign wdata_enable = i_req.wdata[VPSS_BIT_VIDEO_ENABLE];
	assign wdata_switch = i_req.wdata[VPSS_BIT_SWITCH_CLOCK];
	assign wdata_force = i_req.wdata[VPSS_BIT_PLATFORM_SUPPORT];
	assign video_in_use = |socket_video_enable_q;
	// ==========================================================
	// Control registers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			switch_clock_select_q <= VPSS_RST_SWITCH_CLOCK;
		end else if (wr_sys_ctl) begin
			switch_clock_select_q <= wdata_switch;
		end
	end
	// Each socket stores only its own enable and support bit
	generate
		for (genvar g = 0; g < 2; g++) begin : g_sock
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					socket_video_enable_q[g] <= VPSS_RST_VIDEO_ENABLE;
				end else if (wr_sock_ctl && sock_sel[g]) begin
					socket_video_enable_q[g] <= wdata_enable;
				end
			end
			// Force writes only set; support is a platform fact, cleared by reset
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					platform_video_support_q[g] <= VPSS_RST_PLATFORM_SUPPORT;
				end else if (wr_force && sock_sel[g] && wdata_force) begin
					platform_video_support_q[g] <= 1'b1;
				end
			end
		end
	endgenerate
	// ==========================================================
	// Read path
	logic sel_video_enable;
	logic sel_platform_support;
	logic [31:0] sock_ctl_rd;
	logic [31:0] present_rd;
	logic [31:0] sys_ctl_rd;
	logic [31:0] rd_mux;
	logic [31:0] rdata_d;
	assign sel_video_enable = socket_video_enable_q[s];
	assign sel_platform_support = platform_video_support_q[s];
	always_comb begin
		sock_ctl_rd = '0;
		sock_ctl_rd[VPSS_BIT_VIDEO_ENABLE] = sel_video_enable;
		sock_ctl_rd[VPSS_BIT_STD_MODEL] = VPSS_STD_MODEL_IMPL;
		sock_ctl_rd[VPSS_BIT_VIDEO_IN_USE] = video_in_use;
	end
	always_comb begin
		present_rd = '0;
		present_rd[VPSS_BIT_PLATFORM_SUPPORT] = sel_platform_support;
	end
	always_comb begin
		sys_ctl_rd = '0;
		sys_ctl_rd[VPSS_BIT_SWITCH_CLOCK] = switch_clock_select_q;
	end
	// Unmapped offsets and the write-only force register read as zero
	assign rd_mux = addr_sock_ctl ? sock_ctl_rd :
		addr_present ? present_rd :
		addr_sys_ctl ? sys_ctl_rd : 32'h0000_0000;
	// Gated by the strobe so that idle cycles never show stale fields
	assign rdata_d = i_req.rd ? rd_mux : 32'h0000_0000;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= rdata_d;
		end
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req.rd;
		end
	end
	// ==========================================================
	// Internal oscillator
	logic osc_tick;
	logic osc_clk;
	vpss_ring_osc u_osc (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(switch_clock_select_q),
		.o_tick(osc_tick),
		.o_osc(osc_clk)
	);
	// Relayed through a flop so that every top output is registered
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_osc_clock <= 1'b0;
			o_osc_tick <= 1'b0;
		end else begin
			o_osc_clock <= osc_clk;
			o_osc_tick <= osc_tick;
		end
	end
	// ==========================================================
	// Status-change pin pull selection
	// Both type pins high is contradictory; neither pull is then enabled
	logic [1:0] pullup_d;
	logic [1:0] pulldown_d;
	assign pullup_d = c16_q & ~ccb_q;
	assign pulldown_d = ccb_q & ~c16_q;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pullup_en <= '0;
			o_pulldown_en <= '0;
		end else begin
			o_pullup_en <= pullup_d;
			o_pulldown_en <= pulldown_d;
		end
	end
	// ==========================================================
	// Socket power
	// Power-down advances only on the oscillator tick, in flops still clocked by i_clock
	logic [1:0] powered_d;
	assign powered_d = ~pd_q & (c16_q | ccb_q);
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_socket_powered <= '0;
		end else if (osc_tick) begin
			o_socket_powered <= powered_d;
		end
	end
endmodule : vpss_top

//--- bench/vpss_props.sv
/* Port checker for vpss_top.
   Assumes a bind onto vpss_top, one clock domain. */
`timescale 1ns/1ns
module vpss_props
	import vpss_pkg::*;
(
	// Watched ports
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire vpss_req_s i_req,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] i_card_16bit,
	input wire logic [1:0] i_card_cardbus,
	input wire logic [1:0] o_pullup_en,
	input wire logic [1:0] o_pulldown_en,
	input wire logic [1:0] o_socket_powered,
	input wire logic o_osc_clock,
	input wire logic o_osc_tick
);
	// ==========================================
	// Properties
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	wire sc_rd = i_req.rd && i_req.addr == VPSS_OFS_SOCKET_CONTROL;
	std_flag_a: assert property (sc_rd |=> o_rdata[VPSS_BIT_STD_MODEL] == VPSS_STD_MODEL_IMPL)
		else $error("model flag wrong");
	in_use_a: assert property (sc_rd |=>
		(!o_rdata[VPSS_BIT_VIDEO_ENABLE] || o_rdata[VPSS_BIT_VIDEO_IN_USE]))
		else $error("in-use flag missing");
	osc_gap_a: assert property (o_osc_tick |=> !o_osc_tick [*8])
		else $error("ticks too close");
	osc_edge_a: assert property ($changed(o_osc_clock) |-> o_osc_tick || $past(o_osc_tick))
		else $error("osc edge off tick");
	socket_power_a: assert property ($changed(o_socket_powered) |->
		o_osc_tick || $past(o_osc_tick) || $past(o_osc_tick, 2))
		else $error("power change off tick");
	pull_up_a: assert property ((i_card_16bit[0] && !i_card_cardbus[0]) [*5] |->
		o_pullup_en[0] && !o_pulldown_en[0])
		else $error("pull-up missing");
	pull_dn_a: assert property ((!i_card_16bit[1] && i_card_cardbus[1]) [*5] |->
		o_pulldown_en[1] && !o_pullup_en[1])
		else $error("pull-down missing");
endmodule : vpss_props
bind vpss_top vpss_props props_u (.i_clock, .i_rst_n, .i_req, .o_rdata, .i_card_16bit,
	.i_card_cardbus, .o_pullup_en, .o_pulldown_en, .o_socket_powered, .o_osc_clock, .o_osc_tick);

//--- bench/vpss_card_model.sv
/* Inserted card model: card kind per socket to type pins.
   Assumes kinds change off the sampling edge. */
`timescale 1ns/1ns
module vpss_card_model
	import vpss_pkg::*;
(
	// Card kinds
	input wire vpss_card_e i_kind0,
	input wire vpss_card_e i_kind1,
	// Type pins
	output logic [1:0] o_card_16bit,
	output logic [1:0] o_card_cardbus
);
	// ==========================================
	// Pins
	assign o_card_16bit = {i_kind1 == VPSS_CARD_16BIT, i_kind0 == VPSS_CARD_16BIT};
	assign o_card_cardbus = {i_kind1 == VPSS_CARD_CARDBUS, i_kind0 == VPSS_CARD_CARDBUS};
endmodule : vpss_card_model

//--- bench/test_video_port_socket_support.sv
/* Self-checking bench for vpss_top.
   Assumes the card model and the bound checker. */
`timescale 1ns/1ns
module test_video_port_socket_support;
	import vpss_pkg::*;
	// ==========================================
	// Signals
	logic i_clock = 0;
	logic i_rst_n = 0;
	vpss_req_s i_req = '0;
	logic [1:0] pdn = 2'h0;
	vpss_card_e k0 = VPSS_CARD_NONE;
	vpss_card_e k1 = VPSS_CARD_NONE;
	wire logic [1:0] c16, ccb, pu, pd, pw;
	wire logic [31:0] rdata;
	wire logic rvalid, oclk, otick;
	int bad_count = 0;
	int n_compared = 0;
	logic [31:0] rd;
	always #2 i_clock = ~i_clock;
	vpss_card_model card_u (.i_kind0(k0), .i_kind1(k1), .o_card_16bit(c16), .o_card_cardbus(ccb));
	vpss_top dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(i_req), .o_rdata(rdata),
		.o_rvalid(rvalid), .i_card_16bit(c16), .i_card_cardbus(ccb), .o_pullup_en(pu),
		.o_pulldown_en(pd), .i_powerdown_req(pdn), .o_socket_powered(pw),
		.o_osc_clock(oclk), .o_osc_tick(otick));
	// ==========================================
	// Shared tasks
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d errors %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	// Read data stands one cycle, so it is taken at the next falling edge
	task automatic acc(input logic w, input logic [7:0] a, input logic s, input logic [31:0] d);
		@(negedge i_clock);
		i_req = '{wr: w, rd: !w, addr: a, wdata: d, sock: s};
		@(negedge i_clock);
		i_req = '0;
		rd = rdata;
		if (!w) chk(rvalid === 1'b1, "no rvalid");
	endtask : acc
	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(negedge i_clock);
			n++;
		end while (otick !== 1'b1 && n < 8000);
		if (otick !== 1'b1) begin
			chk(0, "no tick");
			summarize();
		end
	endtask : wait_tick
	// ==========================================
	// Scenarios
	localparam int ACT_ENABLE = 0;
	localparam int ACT_BUSY = 1;
	localparam int ACT_NONE = 2;
	localparam int ACT_MOVE = 3;
	localparam int ACT_LEGACY = 4;
	// Host insertion procedure: reads the flags, then enables or declines
	task automatic host(input logic s, output int act);
		logic std;
		logic busy;
		logic own;
		logic other;
		acc(0, VPSS_OFS_SOCKET_CONTROL, s, 0);
		std = rd[VPSS_BIT_STD_MODEL];
		busy = rd[VPSS_BIT_VIDEO_IN_USE];
		acc(0, VPSS_OFS_PRESENT_STATE, s, 0);
		own = rd[VPSS_BIT_PLATFORM_SUPPORT];
		acc(0, VPSS_OFS_PRESENT_STATE, !s, 0);
		other = rd[VPSS_BIT_PLATFORM_SUPPORT];
		if (std !== 1'b1) act = ACT_LEGACY;
		else if (own === 1'b1 && busy === 1'b0) act = ACT_ENABLE;
		else if (own === 1'b1) act = ACT_BUSY;
		else if (other === 1'b1) act = ACT_MOVE;
		else act = ACT_NONE;
		if (act == ACT_ENABLE) acc(1, VPSS_OFS_SOCKET_CONTROL, s, 32'h0000_0200);
	endtask : host
	task automatic t_video;
		acc(0, VPSS_OFS_SOCKET_CONTROL, 0, 0);
		chk(rd[11:9] === 3'b010, "ctrl after reset");
		acc(1, VPSS_OFS_FORCE_EVENT, 0, 32'h0800_0000);
		acc(0, VPSS_OFS_PRESENT_STATE, 0, 0);
		chk(rd[27] === 1'b1, "s0 support");
		acc(0, VPSS_OFS_PRESENT_STATE, 1, 0);
		chk(rd[27] === 1'b0, "s1 support");
		acc(1, VPSS_OFS_SOCKET_CONTROL, 0, 32'h0000_0200);
		acc(0, VPSS_OFS_SOCKET_CONTROL, 1, 0);
		chk(rd[11:9] === 3'b110, "s1 ctrl");
		acc(0, VPSS_OFS_SOCKET_CONTROL, 0, 0);
		chk(rd[11:9] === 3'b111, "s0 ctrl");
		acc(1, VPSS_OFS_SOCKET_CONTROL, 0, 32'h0000_0000);
		acc(0, VPSS_OFS_SOCKET_CONTROL, 1, 0);
		chk(rd[11:9] === 3'b010, "in-use clear");
		$display("t_video done");
	endtask : t_video
	task automatic t_host;
		int act;
		host(1, act);
		chk(act == ACT_MOVE, "s1 move advice");
		host(0, act);
		chk(act == ACT_ENABLE, "s0 enable");
		acc(1, VPSS_OFS_FORCE_EVENT, 1, 32'h0800_0000);
		host(1, act);
		chk(act == ACT_BUSY, "s1 busy");
		acc(0, VPSS_OFS_SOCKET_CONTROL, 1, 0);
		chk(rd[11:9] === 3'b110, "s1 left off");
		$display("t_host done");
	endtask : t_host
	task automatic t_pull;
		k0 = VPSS_CARD_16BIT;
		k1 = VPSS_CARD_CARDBUS;
		repeat (5) @(negedge i_clock);
		chk(pu === 2'b01 && pd === 2'b10, "pull select");
		k0 = VPSS_CARD_NONE;
		k1 = VPSS_CARD_NONE;
		repeat (5) @(negedge i_clock);
		chk(pu === 2'b00 && pd === 2'b00, "pull empty");
		$display("t_pull done");
	endtask : t_pull
	task automatic t_osc;
		int n;
		acc(0, VPSS_OFS_SYSTEM_CONTROL, 0, 0);
		chk(rd[27] === 1'b0, "select reset");
		k0 = VPSS_CARD_CARDBUS;
		repeat (20) @(negedge i_clock);
		chk(otick === 1'b0 && oclk === 1'b0, "osc idle");
		acc(1, VPSS_OFS_SYSTEM_CONTROL, 0, 32'h0800_0000);
		wait_tick(n);
		chk(oclk === 1'b1, "osc high");
		wait_tick(n);
		chk(n == VPSS_OSC_HALF_CYCLES, "osc rate");
		chk(oclk === 1'b0, "osc low");
		chk(pw === 2'b01, "s0 powered");
		pdn = 2'b01;
		wait_tick(n);
		chk(pw === 2'b00, "s0 down");
		$display("t_osc done");
	endtask : t_osc
	// Second reset in mid-run clears support bits, enables and the oscillator
	task automatic t_reset;
		int act;
		i_rst_n = 0;
		repeat (4) @(negedge i_clock);
		chk(pw === 2'b00 && oclk === 1'b0 && rvalid === 1'b0 && pd === 2'b00, "in reset");
		i_rst_n = 1;
		acc(0, VPSS_OFS_SYSTEM_CONTROL, 0, 0);
		chk(rd[27] === 1'b0, "select after reset");
		host(0, act);
		chk(act == ACT_NONE, "no platform support");
		acc(0, VPSS_OFS_SOCKET_CONTROL, 0, 0);
		chk(rd[11:9] === 3'b010, "enables cleared");
		$display("t_reset done");
	endtask : t_reset
	// ==========================================
	// Main sequence
	initial begin
		repeat (4) @(negedge i_clock);
		i_rst_n = 1;
		t_video();
		t_host();
		t_pull();
		t_osc();
		t_reset();
		summarize();
	end
endmodule : test_video_port_socket_support
